// file: design/drb_readback.sv
// Serial frame decoder, register readback shifter and status register.
`timescale 1ns/1ns
`default_nettype none
module drb_readback
  import drb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Serial pins
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  output var logic sdo,
  output var logic sdo_oe_n,
  // Device address pins
  input wire logic device_addr_high,
  input wire logic device_addr_low,
  // Control from the main control register
  input wire logic status_on_every_frame,
  input wire logic packet_error_check,
  input wire logic user_program,
  // Register contents held elsewhere: data, control, gain, offset, clear code, four each
  input wire logic [19:0][15:0] chan_regs,
  input wire logic [drb_pkg::NCH-1:0][15:0] slew_rate_control,
  input wire logic [15:0] main_ctrl_reg,
  input wire logic [15:0] dcdc_ctrl_reg,
  // Channel state
  input wire logic [drb_pkg::NCH-1:0] out_mode_current,
  input wire logic [drb_pkg::NCH-1:0] compliance_lost,
  input wire logic [drb_pkg::NCH-1:0] boost_unregulated,
  input wire logic [drb_pkg::NCH-1:0] iout_fault_in,
  input wire logic [2:0] vout_fault_in,
  input wire logic [drb_pkg::NCH-1:0] ramp_busy,
  // Decoded slew settings
  output var logic [drb_pkg::NCH-1:0] slew_limit_enable,
  output var logic [drb_pkg::NCH-1:0][3:0] slew_update_rate,
  output var logic [drb_pkg::NCH-1:0][2:0] slew_step_size,
  // Status and write hand-off
  output var logic [15:0] fault_and_flag_status,
  output var logic fault_out,
  output var logic wr_strobe,
  output var logic [23:0] wr_word
);
  drb_ev_if ev ();

  drb_pin_sync u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .sclk(sclk),
    .sync_n(sync_n),
    .sdin(sdin),
    .ev(ev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address pins are straps, synchronised and used only after two clocks.
  logic [SYNC_STAGES-1:0] addr_hi_sync_ff;
  logic [SYNC_STAGES-1:0] addr_lo_sync_ff;
  logic [1:0] own_addr;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_hi_sync_ff <= '0;
      addr_lo_sync_ff <= '0;
    end
    else
    begin
      addr_hi_sync_ff <= {addr_hi_sync_ff[SYNC_STAGES-2:0], device_addr_high};
      addr_lo_sync_ff <= {addr_lo_sync_ff[SYNC_STAGES-2:0], device_addr_low};
    end
  end

  assign own_addr = {addr_hi_sync_ff[SYNC_STAGES-1], addr_lo_sync_ff[SYNC_STAGES-1]};

  ////////////////////////////////////////////////////////////////////////////
  // Input shifting, sampled on the falling serial clock edge.
  logic [31:0] in_sh_ff;
  logic [5:0] bit_cnt_ff;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      in_sh_ff <= '0;
      bit_cnt_ff <= '0;
    end
    else if (ev.frame_start)
    begin
      bit_cnt_ff <= '0;
    end
    else if (ev.in_frame && ev.sclk_fall)
    begin
      in_sh_ff <= {in_sh_ff[30:0], ev.sdin_bit};
      if (bit_cnt_ff != 6'h3f)
        bit_cnt_ff <= bit_cnt_ff + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame decode at the frame's closing edge.
  logic [23:0] rx_word;
  logic [7:0] rx_crc;
  logic len_ok;
  logic crc_ok;
  logic frame_ok;
  logic is_read;
  logic addr_match;
  logic [4:0] rx_sel;

  always_comb
  begin
    if (packet_error_check)
    begin
      rx_word = in_sh_ff[31:8];
      rx_crc = in_sh_ff[7:0];
      len_ok = (bit_cnt_ff == 6'(PEC_FRAME_BITS));
    end
    else
    begin
      rx_word = in_sh_ff[23:0];
      rx_crc = CRC_INIT;
      len_ok = (bit_cnt_ff == 6'(FRAME_BITS));
    end
    crc_ok = !packet_error_check || (crc8_24(rx_word) == rx_crc);
    frame_ok = len_ok && crc_ok;
    is_read = rx_word[RW_BIT];
    addr_match = ({rx_word[ADDR_HI_BIT], rx_word[ADDR_LO_BIT]} == own_addr);
    rx_sel = rx_word[SEL_MSB:SEL_LSB];
  end

  logic rd_pending_ff;
  logic [4:0] rd_sel_ff;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_pending_ff <= 1'b0;
      rd_sel_ff <= '0;
    end
    else if (ev.frame_end && frame_ok)
    begin
      // A foreign address drops the request so the output stays released unless status_on_every_frame is set.
      rd_pending_ff <= is_read && addr_match;
      if (is_read && addr_match)
        rd_sel_ff <= rx_sel;
    end
    else if (ev.frame_start)
    begin
      rd_pending_ff <= 1'b0;
    end
  end

  // A no-operation frame only clocks data out; it is loaded into wr_word but raises no wr_strobe.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_strobe <= 1'b0;
      wr_word <= '0;
    end
    else
    begin
      wr_strobe <= ev.frame_end && frame_ok && !is_read && (rx_word != NOP_FRAME);
      if (ev.frame_end && frame_ok && !is_read)
        wr_word <= rx_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback selection.
  logic [15:0] rb_data;

  always_comb
  begin
    rb_data = 16'h0000;
    if (rd_sel_ff < SEL_SLEW)
      rb_data = chan_regs[rd_sel_ff];
    else if (rd_sel_ff < SEL_STATUS)
      rb_data = slew_rate_control[rd_sel_ff[1:0]];
    else if (rd_sel_ff == SEL_STATUS)
      rb_data = fault_and_flag_status;
    else if (rd_sel_ff == SEL_MAINCTL)
      rb_data = main_ctrl_reg;
    else if (rd_sel_ff == SEL_DCDC)
      rb_data = dcdc_ctrl_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output shifting: first bit presented at frame start, next ones on rising edges.
  logic [23:0] tx_word;
  logic [31:0] out_sh_ff;

  always_comb
  begin
    tx_word = {PAD_BYTE, rd_pending_ff ? rb_data : fault_and_flag_status};
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      out_sh_ff <= '0;
      sdo <= 1'b0;
      sdo_oe_n <= 1'b1;
    end
    else if (ev.frame_start)
    begin
      // The CRC is taken over the 24 word bits; it trails only in 32-bit frames.
      out_sh_ff <= {tx_word[22:0], crc8_24(tx_word), 1'b0};
      sdo <= tx_word[23];
      sdo_oe_n <= !(rd_pending_ff || status_on_every_frame);
    end
    else if (ev.frame_end || !ev.in_frame)
    begin
      sdo_oe_n <= 1'b1;
    end
    else if (ev.sclk_rise)
    begin
      sdo <= out_sh_ff[31];
      out_sh_ff <= {out_sh_ff[30:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status register, rebuilt every clock from live channel state.
  logic pec_error_ff;
  logic [NCH-1:0] conv_flag;
  logic [NCH-1:0] iout_fault;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      pec_error_ff <= 1'b0;
    else if (ev.frame_end && packet_error_check)
      pec_error_ff <= !frame_ok;
  end

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++)
    begin : g_chan
      assign conv_flag[ch] = out_mode_current[ch] ? compliance_lost[ch] : boost_unregulated[ch];
      assign iout_fault[ch] = iout_fault_in[ch] | (out_mode_current[ch] & compliance_lost[ch]);

      always_ff @(posedge clk_sys or negedge resetn)
      begin
        if (!resetn)
        begin
          slew_limit_enable[ch] <= 1'b0;
          slew_update_rate[ch] <= '0;
          slew_step_size[ch] <= '0;
        end
        else
        begin
          slew_limit_enable[ch] <= slew_rate_control[ch][SLEW_EN_BIT];
          slew_update_rate[ch] <= slew_rate_control[ch][SLEW_RATE_MSB:SLEW_RATE_LSB];
          slew_step_size[ch] <= slew_rate_control[ch][SLEW_STEP_MSB:SLEW_STEP_LSB];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      fault_and_flag_status <= STATUS_RESET;
      fault_out <= 1'b0;
    end
    else
    begin
      fault_and_flag_status <= STATUS_RESET;
      fault_and_flag_status[ST_CONV_LSB +: NCH] <= conv_flag;
      fault_and_flag_status[ST_TOGGLE] <= user_program;
      fault_and_flag_status[ST_PEC] <= pec_error_ff;
      fault_and_flag_status[ST_RAMP] <= |ramp_busy;
      fault_and_flag_status[ST_VFAULT_LSB +: 3] <= vout_fault_in;
      fault_and_flag_status[ST_IFAULT_LSB +: NCH] <= iout_fault;
      // Converter flags are left out on purpose so that a voltage-mode boost sag only reports.
      fault_out <= |iout_fault | |vout_fault_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence seq_read_end;
    ev.frame_end && frame_ok && is_read && addr_match;
  endsequence

  sequence seq_pec_bad;
    ev.frame_end && packet_error_check && !frame_ok;
  endsequence

  a_read_pending: assert property (@(posedge clk_sys) disable iff (!resetn)
    seq_read_end |=> rd_pending_ff && rd_sel_ff == $past(rx_sel))
    else $error("read request not latched");

  a_write_no_pend: assert property (@(posedge clk_sys) disable iff (!resetn)
    ev.frame_end && frame_ok && !is_read |=> !rd_pending_ff)
    else $error("write frame left a read pending");

  // Remembers that the last accepted frame was a read for another device.
  logic foreign_rd_ff;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      foreign_rd_ff <= 1'b0;
    else if (ev.frame_end && frame_ok)
      foreign_rd_ff <= is_read && !addr_match;
  end

  a_foreign_addr: assert property (@(posedge clk_sys) disable iff (!resetn)
    foreign_rd_ff && ev.frame_start && !status_on_every_frame |=> sdo_oe_n)
    else $error("foreign address drove output");

  a_read_drives: assert property (@(posedge clk_sys) disable iff (!resetn)
    ev.frame_start && rd_pending_ff |=> !sdo_oe_n && sdo == 1'b0)
    else $error("readback frame not driven");

  a_shift_rise: assert property (@(posedge clk_sys) disable iff (!resetn)
    ev.in_frame && ev.sclk_rise && !ev.frame_start && !ev.frame_end |=> sdo == $past(out_sh_ff[31]))
    else $error("output did not shift on rising edge");

  a_hold_fall: assert property (@(posedge clk_sys) disable iff (!resetn)
    ev.in_frame && !ev.sclk_rise && !ev.frame_start |=> $stable(sdo))
    else $error("output changed off a rising edge");

  a_unused_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_sel_ff > SEL_DCDC |-> rb_data == 16'h0000)
    else $error("unused select returned data");

  a_pec_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
    seq_pec_bad |=> ##1 fault_and_flag_status[ST_PEC])
    else $error("packet error not flagged");

  a_toggle_follow: assert property (@(posedge clk_sys) disable iff (!resetn)
    ##1 fault_and_flag_status[ST_TOGGLE] == $past(user_program))
    else $error("toggle bit does not follow");

  a_conv_current: assert property (@(posedge clk_sys) disable iff (!resetn)
    out_mode_current[0] && compliance_lost[0] |=> fault_and_flag_status[ST_CONV_LSB]
      && fault_and_flag_status[ST_IFAULT_LSB])
    else $error("compliance loss not flagged twice");

  a_conv_no_fault: assert property (@(posedge clk_sys) disable iff (!resetn)
    !(|iout_fault) && !(|vout_fault_in) && |conv_flag |=> !fault_out)
    else $error("converter flag raised fault output");

  a_status_frame: assert property (@(posedge clk_sys) disable iff (!resetn)
    ev.frame_start && status_on_every_frame |=> !sdo_oe_n)
    else $error("status not streamed");
endmodule
`default_nettype wire

// file: design/drb_pkg.sv
// Constants, field layouts and helper functions for the serial readback and status block.
// Functional notes
// - Top frame bit set means read request.
// - Address bits plus select choose register; low ignored.
// - Next frame returns 24 bits, data in low 16.
// - Output changes on rising edge, host samples falling.
// - With error checking, 32 bits incl. CRC.
// - No-operation frame value is fixed 0x3CE000.
// - Select 0-15: data, control, gain, offset.
// - Select 16-23: clear code, slew control.
// - Select 24-26: status, main, converter control.
// - Slew word: enable, update rate, step fields.
// - Slew limiting configured independently per channel.
// - Status read-only; ramp bit 9, toggle 11.
// - Status streams on every frame when enabled; the frame after a read returns the read data instead.
// - Status bit layout: converter, error, faults.
// - Current mode compliance loss sets both flags.
// - Voltage mode regulation failure sets converter flag.
// - Voltage-mode converter flags never raise fault pin.
// - Error flag marks CRC mismatch, last word.
// - Ramp flag while any channel slews.
// - Toggle flag follows user program bit.
`default_nettype none
package drb_pkg;
  localparam int NCH = 4;
  localparam int SYNC_STAGES = 2;
  localparam int FRAME_BITS = 24;
  localparam int PEC_FRAME_BITS = 32;
  localparam int CRC_BITS = 8;
  localparam int RW_BIT = 23;
  localparam int ADDR_HI_BIT = 22;
  localparam int ADDR_LO_BIT = 21;
  localparam int SEL_MSB = 20;
  localparam int SEL_LSB = 16;
  localparam logic [23:0] NOP_FRAME = 24'h3ce000;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  localparam logic [4:0] SEL_DATA = 5'h00;
  localparam logic [4:0] SEL_CTRL = 5'h04;
  localparam logic [4:0] SEL_GAIN = 5'h08;
  localparam logic [4:0] SEL_OFFS = 5'h0c;
  localparam logic [4:0] SEL_CLR = 5'h10;
  localparam logic [4:0] SEL_SLEW = 5'h14;
  localparam logic [4:0] SEL_STATUS = 5'h18;
  localparam logic [4:0] SEL_MAINCTL = 5'h19;
  localparam logic [4:0] SEL_DCDC = 5'h1a;
  localparam int ST_CONV_LSB = 12;
  localparam int ST_TOGGLE = 11;
  localparam int ST_PEC = 10;
  localparam int ST_RAMP = 9;
  localparam int ST_VFAULT_LSB = 4;
  localparam int ST_IFAULT_LSB = 0;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam int SLEW_EN_BIT = 12;
  localparam int SLEW_RATE_MSB = 6;
  localparam int SLEW_RATE_LSB = 3;
  localparam int SLEW_STEP_MSB = 2;
  localparam int SLEW_STEP_LSB = 0;

  // Bit-serial CRC-8, most significant data bit first.
  function automatic logic [7:0] crc8_24(input logic [23:0] d);
    logic [7:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = 23; i >= 0; i--)
    begin
      fb = c[7] ^ d[i];
      c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction
endpackage
`default_nettype wire

// file: design/drb_ev_if.sv
// Synchronised serial-pin events passed from the pin sampler to the frame logic.
`timescale 1ns/1ns
`default_nettype none
interface drb_ev_if;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_start;
  logic frame_end;
  logic in_frame;
  logic sdin_bit;
  modport src (output sclk_rise, sclk_fall, frame_start, frame_end, in_frame, sdin_bit);
  modport dst (input sclk_rise, sclk_fall, frame_start, frame_end, in_frame, sdin_bit);
endinterface
`default_nettype wire

// file: design/drb_pin_sync.sv
// Two-stage pin synchronisers and edge detection for the serial clock, frame and data pins.
`timescale 1ns/1ns
`default_nettype none
module drb_pin_sync
  import drb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Raw pins
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  // Events
  drb_ev_if.src ev
);
  // The serial clock and frame pins idle high, so their chains reset to one to avoid a false edge; the data chain resets to zero.
  logic [SYNC_STAGES-1:0] sclk_sync_ff;
  logic [SYNC_STAGES-1:0] sync_n_sync_ff;
  logic [SYNC_STAGES-1:0] sdin_sync_ff;
  logic sclk_last_ff;
  logic sync_n_last_ff;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      sclk_sync_ff <= '1;
      sync_n_sync_ff <= '1;
      sdin_sync_ff <= '0;
    end
    else
    begin
      sclk_sync_ff <= {sclk_sync_ff[SYNC_STAGES-2:0], sclk};
      sync_n_sync_ff <= {sync_n_sync_ff[SYNC_STAGES-2:0], sync_n};
      sdin_sync_ff <= {sdin_sync_ff[SYNC_STAGES-2:0], sdin};
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      sclk_last_ff <= 1'b1;
      sync_n_last_ff <= 1'b1;
    end
    else
    begin
      sclk_last_ff <= sclk_sync_ff[SYNC_STAGES-1];
      sync_n_last_ff <= sync_n_sync_ff[SYNC_STAGES-1];
    end
  end

  assign ev.sclk_rise = sclk_sync_ff[SYNC_STAGES-1] & ~sclk_last_ff;
  assign ev.sclk_fall = ~sclk_sync_ff[SYNC_STAGES-1] & sclk_last_ff;
  assign ev.frame_start = ~sync_n_sync_ff[SYNC_STAGES-1] & sync_n_last_ff;
  assign ev.frame_end = sync_n_sync_ff[SYNC_STAGES-1] & ~sync_n_last_ff;
  assign ev.in_frame = ~sync_n_sync_ff[SYNC_STAGES-1];
  assign ev.sdin_bit = sdin_sync_ff[SYNC_STAGES-1];
endmodule
`default_nettype wire

// file: tb/drb_host.sv
// Host model that frames, clocks and samples the serial readback link.
`timescale 1ns/1ns
`default_nettype none
module drb_host (
  // Clock
  input wire logic clk_sys,
  // Serial pins
  output logic sclk,
  output logic sync_n,
  output logic sdin,
  input wire logic sdo,
  input wire logic sdo_oe_n
);
  logic drove;
  initial
  begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdin = 1'b0;
    drove = 1'b0;
  end
  // Pins move on falling clk_sys edges, four per half period, so the 80 ns clock never races the sampler.
  task automatic half();
    repeat (4) @(negedge clk_sys);
  endtask
  // The serial clock stands idle high between frames, which also keeps the CRC of a readback valid.
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    drove = 1'b0;
    half();
    sync_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      sdin = tx[i];
      half();
      sclk = 1'b0;
      // A released line reads as the inverse of its last value, so a check on undriven data fails.
      rx[i] = sdo_oe_n ? !sdo : sdo;
      drove = drove | !sdo_oe_n;
      half();
      sclk = 1'b1;
    end
    half();
    sync_n = 1'b1;
    sdin = !sdin;
  endtask
endmodule
`default_nettype wire

// file: tb/dac_serial_readback_status_test.sv
// Self-checking bench for the serial readback and status block.
`timescale 1ns/1ns
`default_nettype none
module dac_serial_readback_status_test;
  import drb_pkg::*;
  logic clk_sys, resetn, sclk, sync_n, sdin, sdo, sdo_oe_n, fault_out, wr_strobe;
  logic device_addr_high, device_addr_low, status_on_every_frame, packet_error_check, user_program;
  logic [19:0][15:0] chan_regs;
  logic [NCH-1:0][15:0] slew_rate_control;
  logic [15:0] main_ctrl_reg, dcdc_ctrl_reg, fault_and_flag_status;
  logic [NCH-1:0] out_mode_current, compliance_lost, boost_unregulated, iout_fault_in, ramp_busy;
  logic [NCH-1:0] slew_limit_enable;
  logic [2:0] vout_fault_in;
  logic [NCH-1:0][3:0] slew_update_rate;
  logic [NCH-1:0][2:0] slew_step_size;
  logic [23:0] wr_word, w;
  logic [31:0] seed = 32'h84e6;
  logic [31:0] rx;
  int num_errors = 0;
  int total_checks = 0;
  int nstb = 0;

  drb_readback dut (.clk_sys, .resetn, .sclk, .sync_n, .sdin, .sdo, .sdo_oe_n, .device_addr_high,
    .device_addr_low, .status_on_every_frame, .packet_error_check, .user_program, .chan_regs,
    .slew_rate_control, .main_ctrl_reg, .dcdc_ctrl_reg, .out_mode_current, .compliance_lost,
    .boost_unregulated, .iout_fault_in, .vout_fault_in, .ramp_busy, .slew_limit_enable,
    .slew_update_rate, .slew_step_size, .fault_and_flag_status, .fault_out, .wr_strobe, .wr_word);
  drb_host host (.clk_sys, .sclk, .sync_n, .sdin, .sdo, .sdo_oe_n);

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    if (wr_strobe === 1'b1)
      nstb++;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction
  function automatic logic [7:0] crc(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  function automatic logic [15:0] exp_st(input logic pe);
    logic [3:0] cv;
    cv = (out_mode_current & compliance_lost) | (~out_mode_current & boost_unregulated);
    return {cv, user_program, pe, |ramp_busy, 2'b00, vout_fault_in, iout_fault_in | (out_mode_current & compliance_lost)};
  endfunction
  function automatic logic [15:0] exp_reg(input logic [4:0] s);
    if (s < 5'd20)
      return chan_regs[s];
    if (s < 5'd24)
      return slew_rate_control[s[1:0]];
    case (s)
      5'd24: return exp_st(1'b0);
      5'd25: return main_ctrl_reg;
      5'd26: return dcdc_ctrl_reg;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // A whole frame; with error checking on the host appends its own CRC.
  task automatic fr(input logic [23:0] fw);
    if (packet_error_check)
      host.xfer({fw, crc(fw)}, 32, rx);
    else
      host.xfer({8'h00, fw}, 24, rx);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {resetn, status_on_every_frame, packet_error_check, user_program} = '0;
    {device_addr_high, device_addr_low} = 2'b10;
    {out_mode_current, compliance_lost, boost_unregulated, iout_fault_in, ramp_busy, vout_fault_in} = '0;
    for (int i = 0; i < 20; i++)
      chan_regs[i] = rnd();
    for (int i = 0; i < NCH; i++)
      slew_rate_control[i] = rnd();
    main_ctrl_reg = rnd();
    dcdc_ctrl_reg = rnd();
    repeat (15) @(negedge clk_sys);
    chk(sdo_oe_n, 1);
    chk(fault_and_flag_status, 0);
    @(negedge clk_sys);
    resetn = 1'b1;
    repeat (8) @(negedge clk_sys);
    $display("reset test done");
    // Back-to-back reads over every select, the last one closed by a no-operation frame.
    for (int s = 0; s < 33; s++)
    begin
      fr(s < 32 ? {3'b110, 5'(s), rnd()} : NOP_FRAME);
      if (s > 0)
        chk(rx, {8'h00, exp_reg(5'(s - 1))});
    end
    chk(nstb, 0);
    $display("readback sweep done");
    fr({3'b101, 5'd8, 16'h0000});
    fr(NOP_FRAME);
    chk(host.drove, 0);
    $display("foreign address test done");
    for (int k = 0; k < 4; k++)
    begin
      w = 24'({rnd(), rnd()}) & 24'h7fffff;
      fr(w);
      repeat (8) @(negedge clk_sys);
      chk(wr_word, w);
      chk(nstb, k + 1);
    end
    fr(NOP_FRAME);
    repeat (8) @(negedge clk_sys);
    chk(nstb, 4);
    status_on_every_frame = 1'b1;
    user_program = 1'b1;
    fr(24'h123456);
    chk(rx, {8'h00, exp_st(1'b0)});
    status_on_every_frame = 1'b0;
    $display("write and status frame test done");
    for (int k = 0; k < 24; k++)
    begin
      @(negedge clk_sys);
      {out_mode_current, compliance_lost, boost_unregulated, iout_fault_in} = rnd();
      {ramp_busy, vout_fault_in, user_program} = 8'(rnd());
      slew_rate_control[k % 4] = rnd();
      repeat (3) @(negedge clk_sys);
      chk(fault_and_flag_status, exp_st(1'b0));
      if ((out_mode_current & compliance_lost) == 4'h0)
        chk(fault_out, |{iout_fault_in, vout_fault_in});
      for (int c = 0; c < NCH; c++)
        chk({slew_limit_enable[c], slew_update_rate[c], slew_step_size[c]},
          {slew_rate_control[c][12], slew_rate_control[c][6:3], slew_rate_control[c][2:0]});
    end
    // Voltage-mode boost sag alone reports but must not raise the fault pin.
    {out_mode_current, compliance_lost, iout_fault_in, vout_fault_in} = '0;
    boost_unregulated = 4'h5;
    repeat (3) @(negedge clk_sys);
    chk(fault_and_flag_status[15:12], 4'h5);
    chk(fault_and_flag_status, exp_st(1'b0));
    chk(fault_out, 0);
    $display("status and slew test done");
    packet_error_check = 1'b1;
    fr({3'b110, SEL_GAIN, 16'h0000});
    fr(NOP_FRAME);
    chk(rx[31:8], {8'h00, chan_regs[8]});
    chk(rx[7:0], crc({8'h00, chan_regs[8]}));
    host.xfer({NOP_FRAME, ~crc(NOP_FRAME)}, 32, rx);
    repeat (8) @(negedge clk_sys);
    chk(fault_and_flag_status[10], 1);
    fr(NOP_FRAME);
    repeat (8) @(negedge clk_sys);
    chk(fault_and_flag_status[10], 0);
    $display("packet error test done");
    results();
  end
endmodule
`default_nettype wire
